// File: inc/qei_map.svh
/*
 register offsets, field positions and reset values of the quadrature encoder interface.
 assumes: included by bare name from the design only.
*/
`ifndef QEI_MAP_SVH
`define QEI_MAP_SVH
// ==================================================
// register byte offsets
`define QEI_OFF_STATUS 12'h000
`define QEI_OFF_LIMIT 12'h004
`define QEI_OFF_CONTROL 12'h008
`define QEI_OFF_COUNT 12'h00c
`define QEI_OFF_TIMER 12'h010
`define QEI_OFF_RELOAD 12'h014
`define QEI_OFF_PRESCALE 12'h018
`define QEI_OFF_INTERVAL 12'h01c
`define QEI_OFF_ELAPSED 12'h020
`define QEI_OFF_CNT_SNAP 12'h024
// ==================================================
// control field positions
`define QEI_CTL_SWAP 0
`define QEI_CTL_INDEX 1
`define QEI_CTL_FIRST 2
`define QEI_CTL_CHECK 3
`define QEI_CTL_SNAP 4
`define QEI_CTL_TIMER 5
// ==================================================
// status field positions
`define QEI_ST_ERROR 0
`define QEI_ST_DIR 1
`define QEI_ST_UNINIT 2
`define QEI_ST_A 3
`define QEI_ST_B 4
`define QEI_ST_INDEX 5
`define QEI_ST_FIRST 6
// ==================================================
// reset values
`define QEI_RST_CONTROL 6'h00
`define QEI_RST_WORD 16'h0000
`define QEI_RST_PRESCALE 8'h00
`endif

// File: inc/qei_pkg.sv
/*
 types of the quadrature encoder interface.
 assumes: nothing beyond the compiler.
*/
package qei_pkg;
   // ==================================================
   // control register fields
   typedef struct packed {
      logic timer_enable;
      logic snapshot_on_timeout;
      logic count_check_enable;
      logic first_index_only;
      logic index_reset_enable;
      logic swap_direction;
   } qei_control_t;
   // quadrature pins in one group
   typedef struct packed {
      logic index_in;
      logic quad_in_b;
      logic quad_in_a;
   } qei_pins_t;
   // edge that carried the first index reset
   typedef enum logic [1:0] {
      qei_edge_a_rise, qei_edge_a_fall, qei_edge_b_rise, qei_edge_b_fall
   } qei_edge_t;
   // index alignment states
   typedef enum logic [1:0] {
      qei_idle, qei_armed, qei_done
   } qei_state_t;
endpackage

// File: src/qei_top.sv
/*
 quadrature encoder interface: position counter, index reset and check, loop timer, snapshots, apb slave.
 assumes: pins synchronous enough for a two stage synchroniser, apb master on sys_clk_i, external irq masking.
*/
// The register addresses and the APB interface to the registers are this design's own decisions.
`include "qei_map.svh"
module qei_top (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // encoder pins
   input wire logic quad_in_a_i,
   input wire logic quad_in_b_i,
   input wire logic index_in_i,
   // edge interval timer values
   input wire logic [15:0] interval_time_i,
   input wire logic [15:0] elapsed_time_i,
   // unit interrupt
   output logic irq_o
);
   // ==================================================
   // reset release
   logic [1:0] rst_sync;
   logic rst_n;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) rst_sync <= 2'h0;
      else rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // ==================================================
   // pin synchronisers and edge history
   qei_pkg::qei_pins_t pin_meta, pin_sync, pin_prev;
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 3'h0;
         pin_sync <= 3'h0;
         pin_prev <= 3'h0;
      end else begin
         pin_meta <= {index_in_i, quad_in_b_i, quad_in_a_i};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ==================================================
   // registers
   qei_pkg::qei_control_t ctl;
   logic [15:0] count_limit, position_count, loop_timer_count, loop_timer_reload;
   logic [7:0] loop_timer_prescale, pre_cnt;
   logic [15:0] interval_snap, elapsed_snap, count_snap;
   logic limit_written, dir_up, err_flag, first_seen, marker_pend;
   qei_pkg::qei_state_t align_state;
   qei_pkg::qei_edge_t align_edge;

   // ==================================================
   // apb decode
   wire access = psel_i && penable_i;
   wire wr = access && pwrite_i;
   wire rd = access && !pwrite_i;
   wire hit_status = paddr_i == `QEI_OFF_STATUS;
   wire hit_limit = paddr_i == `QEI_OFF_LIMIT;
   wire hit_ctl = paddr_i == `QEI_OFF_CONTROL;
   wire hit_count = paddr_i == `QEI_OFF_COUNT;
   wire hit_timer = paddr_i == `QEI_OFF_TIMER;
   wire hit_reload = paddr_i == `QEI_OFF_RELOAD;
   wire hit_pre = paddr_i == `QEI_OFF_PRESCALE;
   wire hit_int = paddr_i == `QEI_OFF_INTERVAL;
   wire hit_ela = paddr_i == `QEI_OFF_ELAPSED;
   wire hit_csnap = paddr_i == `QEI_OFF_CNT_SNAP;
   wire mapped = hit_status | hit_limit | hit_ctl | hit_count | hit_timer | hit_reload | hit_pre |
                 hit_int | hit_ela | hit_csnap;

   // ==================================================
   // quadrature decode on counter inputs
   wire a_now = ctl.swap_direction ? pin_sync.quad_in_b : pin_sync.quad_in_a;
   wire b_now = ctl.swap_direction ? pin_sync.quad_in_a : pin_sync.quad_in_b;
   wire a_old = ctl.swap_direction ? pin_prev.quad_in_b : pin_prev.quad_in_a;
   wire b_old = ctl.swap_direction ? pin_prev.quad_in_a : pin_prev.quad_in_b;
   wire a_edge = a_now ^ a_old;
   wire b_edge = b_now ^ b_old;
   wire q_edge = a_edge ^ b_edge;
   // a leading b: a edge gives a != b, b edge gives a == b
   wire fwd = a_edge ? (a_now != b_now) : (a_now == b_now);
   // which edge this is, in forward terms; reverse uses the opposite polarity
   wire [1:0] edge_code = a_edge ? {1'b0, ~a_now} : {1'b1, ~b_now};
   wire [1:0] edge_fwd = fwd ? edge_code : {edge_code[1], ~edge_code[0]};
   wire idx_rise = pin_sync.index_in && !pin_prev.index_in;
   wire idx_fall = !pin_sync.index_in && pin_prev.index_in;
   wire marker = ctl.index_reset_enable && (dir_up ? idx_rise : idx_fall);
   wire first_ok = !(ctl.first_index_only && first_seen);
   wire edge_match = (align_state == qei_pkg::qei_idle) ? 1'b1 : (edge_fwd == align_edge);
   wire do_index = q_edge && (marker_pend || marker) && edge_match && first_ok;
   wire [15:0] index_val = fwd ? `QEI_RST_WORD : count_limit;
   wire [15:0] wrap_val = fwd ? ((position_count == count_limit) ? `QEI_RST_WORD : position_count + 16'h0001)
                          : ((position_count == `QEI_RST_WORD) ? count_limit : position_count - 16'h0001);
   wire [15:0] next_count = do_index ? index_val : wrap_val;
   wire [15:0] expect_val = dir_up ? `QEI_RST_WORD : count_limit;
   wire check_on = ctl.count_check_enable && ctl.index_reset_enable;
   wire mismatch = check_on && marker && (position_count != expect_val);

   // ==================================================
   // loop timer
   wire pre_tick = ctl.timer_enable && (pre_cnt == `QEI_RST_PRESCALE);
   wire timeout = pre_tick && (loop_timer_count == `QEI_RST_WORD);

   // ==================================================
   // status word
   wire [15:0] status = {9'h000, first_seen, pin_sync.index_in, pin_sync.quad_in_b, pin_sync.quad_in_a,
                         !limit_written, dir_up, err_flag};
   wire [15:0] rd_mux = hit_status ? status :
                        hit_limit ? count_limit :
                        hit_ctl ? {10'h000, ctl} :
                        hit_count ? position_count :
                        hit_timer ? loop_timer_count :
                        hit_reload ? loop_timer_reload :
                        hit_pre ? {8'h00, loop_timer_prescale} :
                        hit_int ? interval_snap :
                        hit_ela ? elapsed_snap :
                        hit_csnap ? count_snap : 16'h0000;

   // control, limit, reload and prescale registers
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= `QEI_RST_CONTROL;
         count_limit <= `QEI_RST_WORD;
         limit_written <= 1'b0;
         loop_timer_reload <= `QEI_RST_WORD;
         loop_timer_prescale <= `QEI_RST_PRESCALE;
      end else if (wr) begin
         if (hit_ctl) ctl <= pwdata_i[5:0];
         if (hit_limit) begin
            count_limit <= pwdata_i[15:0];
            limit_written <= 1'b1;
         end
         if (hit_reload) loop_timer_reload <= pwdata_i[15:0];
         if (hit_pre) loop_timer_prescale <= pwdata_i[7:0];
      end
   end

   // position counter and direction; hardware edge wins over a write
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         position_count <= `QEI_RST_WORD;
         dir_up <= 1'b1;
      end else if (q_edge) begin
         position_count <= next_count;
         dir_up <= fwd;
      end else if (wr && hit_count) begin
         position_count <= pwdata_i[15:0];
      end
   end

   // marker pending, edge alignment and first marker flag
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         marker_pend <= 1'b0;
         align_state <= qei_pkg::qei_idle;
         align_edge <= qei_pkg::qei_edge_a_rise;
         first_seen <= 1'b0;
      end else begin
         if (!ctl.index_reset_enable) marker_pend <= 1'b0;
         else if (do_index) marker_pend <= 1'b0;
         else if (marker && first_ok) marker_pend <= 1'b1;
         if (do_index && align_state == qei_pkg::qei_idle) begin
            align_edge <= qei_pkg::qei_edge_t'(edge_fwd);
            align_state <= qei_pkg::qei_done;
         end
         if (marker && ctl.first_index_only) first_seen <= 1'b1;
      end
   end

   // count check error, set wins, cleared by a matching marker
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) err_flag <= 1'b0;
      else if (mismatch) err_flag <= 1'b1;
      else if (check_on && marker) err_flag <= 1'b0;
   end

   // loop timer prescaler and count
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt <= `QEI_RST_PRESCALE;
         loop_timer_count <= `QEI_RST_WORD;
      end else begin
         if (!ctl.timer_enable) pre_cnt <= loop_timer_prescale;
         else if (pre_tick) pre_cnt <= loop_timer_prescale;
         else pre_cnt <= pre_cnt - 8'h01;
         if (timeout) loop_timer_count <= loop_timer_reload;
         else if (pre_tick) loop_timer_count <= loop_timer_count - 16'h0001;
         else if (wr && hit_timer) loop_timer_count <= pwdata_i[15:0];
      end
   end

   // snapshots on timeout or count read
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         interval_snap <= `QEI_RST_WORD;
         elapsed_snap <= `QEI_RST_WORD;
         count_snap <= `QEI_RST_WORD;
      end else if (ctl.snapshot_on_timeout ? timeout : (rd && hit_count)) begin
         interval_snap <= interval_time_i;
         elapsed_snap <= elapsed_time_i;
         if (ctl.snapshot_on_timeout) count_snap <= position_count;
      end
   end

   // apb answer and interrupt outputs
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o <= 32'h00000000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !mapped;
         prdata_o <= {16'h0000, rd_mux};
         irq_o <= timeout || mismatch;
      end
   end
endmodule

// File: tb/qei_top_chk.sv
/*
 port checker of the encoder unit.
 assumes: bound to qei_top, one clock, reset low.
*/
module qei_top_chk (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // pins and interrupt
   input wire logic quad_in_a_i,
   input wire logic quad_in_b_i,
   input wire logic index_in_i,
   input wire logic irq_o
);
   // ==========
   // bus steps and steady pins
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_access; psel_i && penable_i && pready_o; endsequence
   sequence s_steady; ($stable(quad_in_a_i) && $stable(quad_in_b_i) && $stable(index_in_i))[*5]; endsequence
   // ==========
   // properties
   property p_ready; s_setup |=> s_access; endproperty
   property p_gate; pready_o |-> psel_i && penable_i; endproperty
   property p_err; pslverr_o |-> pready_o; endproperty
   property p_hole; s_setup ##0 (paddr_i > 12'h024) |=> pslverr_o && prdata_o == 32'h0; endproperty
   property p_mapped; s_setup ##0 (paddr_i <= 12'h024 && paddr_i[1:0] == 2'h0) |=> !pslverr_o; endproperty
   property p_upper; pready_o |-> prdata_o[31:16] == 16'h0000; endproperty
   property p_pulse; irq_o |=> !irq_o; endproperty
   property p_pins;
      s_steady ##0 (pready_o && paddr_i == 12'h000)
         |-> prdata_o[5:3] == {index_in_i, quad_in_b_i, quad_in_a_i};
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_gate: assert property (p_gate) else $error("ready outside access");
   a_err: assert property (p_err) else $error("error without ready");
   a_hole: assert property (p_hole) else $error("unmapped access not refused");
   a_mapped: assert property (p_mapped) else $error("mapped access refused");
   a_upper: assert property (p_upper) else $error("upper read bits set");
   a_pulse: assert property (p_pulse) else $error("interrupt longer than one cycle");
   a_pins: assert property (p_pins) else $error("pin levels wrong in status");
endmodule
bind qei_top qei_top_chk u_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .quad_in_a_i(quad_in_a_i), .quad_in_b_i(quad_in_b_i),
   .index_in_i(index_in_i), .irq_o(irq_o));

// File: tb/qei_enc_model.sv
/*
 incremental encoder with index, one edge per request.
 assumes: requests spaced by the bench.
*/
module qei_enc_model (
   // clock and commands
   input wire logic clk_i,
   input wire logic step_i,
   input wire logic fwd_i,
   input wire logic mark_i,
   // encoder pins
   output logic a_o,
   output logic b_o,
   output logic z_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase = 2'h0;
   // one quadrature edge per request, spacing kept by caller
   always @(posedge clk_i) begin
      if (step_i) phase <= fwd_i ? phase + 2'h1 : phase - 2'h1;
   end
   // a leads b when moving forward
   assign a_o = phase[0] ^ phase[1];
   assign b_o = phase[1];
   assign z_o = mark_i;
endmodule

// File: tb/qei_top_tb.sv
/*
 self-checking bench of the encoder unit.
 assumes: apb slave answers in one access cycle.
*/
module qei_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, qa, qb, qz, irq, e;
   logic step = 1'b0, fwd = 1'b1, mark = 1'b0;
   logic [15:0] ivl = 16'h1234, ela = 16'h5678;
   int num_errors = 0, check_count = 0, irq_count = 0;
   // clock and interrupt pulse counter
   always #5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (irq === 1'b1) irq_count++;
   // encoder and design
   qei_enc_model enc (.clk_i(sys_clk), .step_i(step), .fwd_i(fwd), .mark_i(mark), .a_o(qa), .b_o(qb), .z_o(qz));
   qei_top dut (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .quad_in_a_i(qa), .quad_in_b_i(qb), .index_in_i(qz), .interval_time_i(ivl), .elapsed_time_i(ela),
      .irq_o(irq));
   // ==========
   // tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // quadrature edges seven cycles apart
   task automatic mv(input logic f, input int n);
      repeat (n) begin
         step <= 1'b1;
         fwd <= f;
         @(posedge sys_clk);
         step <= 1'b0;
         repeat (6) @(posedge sys_clk);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========
   // watchdog
   initial begin
      repeat (5000) @(posedge sys_clk);
      num_errors++;
      give_verdict;
   end
   // ==========
   // tests
   initial begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(12'h000, 32'h6);
      rd(12'h008, 32'h0);
      $display("reset values done");
      wr(12'h004, 32'hf);
      rd(12'h000, 32'h2);
      mv(1'b1, 5);
      rd(12'h00c, 32'h5);
      rd(12'h000, 32'ha);
      mv(1'b0, 7);
      rd(12'h00c, 32'he);
      rd(12'h000, 32'h18);
      wr(12'h008, 32'h1);
      mv(1'b1, 2);
      rd(12'h00c, 32'hc);
      rd(12'h008, 32'h1);
      $display("counting done");
      wr(12'h008, 32'ha);
      wr(12'h00c, 32'h3);
      mv(1'b1, 1);
      irq_count = 0;
      mark <= 1'b1;
      repeat (6) @(posedge sys_clk);
      mv(1'b1, 1);
      rd(12'h00c, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(q & 32'h3, 32'h3);
      chk(32'(irq_count), 32'h1);
      wr(12'h008, 32'h0);
      mark <= 1'b0;
      $display("index done");
      wr(12'h010, 32'h5);
      repeat (20) @(posedge sys_clk);
      rd(12'h010, 32'h5);
      wr(12'h018, 32'h1);
      wr(12'h014, 32'h3);
      wr(12'h008, 32'h30);
      repeat (16) @(posedge sys_clk);
      irq_count = 0;
      repeat (80) @(posedge sys_clk);
      chk(32'(irq_count), 32'ha);
      rd(12'h01c, 32'h1234);
      rd(12'h020, 32'h5678);
      rd(12'h024, 32'h0);
      wr(12'h008, 32'h0);
      ivl <= 16'h0abc;
      @(posedge sys_clk);
      rd(12'h00c, 32'h0);
      rd(12'h01c, 32'habc);
      $display("timer done");
      apb(1'b0, 12'h040, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("unmapped done");
      give_verdict;
   end
endmodule
